// ### rtl/alu_regs.svh
// Constants of the arithmetic and logic datapath: widths, masks, cycle counts.
// Assumes inclusion by bare name from the package and design files.
`ifndef ALU_REGS_SVH
`define ALU_REGS_SVH

`define DATA_W          8
`define WORD_W          16
`define ALL_ONES        8'hFF
`define ALL_ZEROS       8'h00
`define ONE_BYTE        8'h01
`define ZERO_WORD       16'h0000
`define SIGN_BIT        7
`define WORD_SIGN_BIT   15
`define HALF_BIT        3
`define MAX_POS         8'h7F
`define MIN_NEG         8'h80
`define SHORT_CYCLES    1
`define LONG_CYCLES     2
`define FLAG_C          0
`define FLAG_Z          1
`define FLAG_N          2
`define FLAG_V          3
`define FLAG_S          4
`define FLAG_H          5
`define FLAGS_RESET     6'h00

`endif

// ### rtl/alu_pkg.sv
// Types of the arithmetic and logic datapath: operation codes and carriers.
// Assumes alu_regs.svh is on the include path.
`default_nettype none
`include "alu_regs.svh"

package alu_pkg;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_SUM,
    OP_SUM_CARRY,
    OP_WORD_IMMEDIATE_SUM,
    OP_DIFFERENCE,
    OP_DIFFERENCE_CONSTANT,
    OP_BORROW_DIFFERENCE,
    OP_BORROW_CONSTANT_DIFFERENCE,
    OP_WORD_IMMEDIATE_DIFFERENCE,
    OP_AND,
    OP_OR,
    OP_EXCLUSIVE_OR,
    OP_BITWISE_INVERT,
    OP_ARITHMETIC_INVERSE,
    OP_BIT_SETTING,
    OP_BIT_CLEARING,
    OP_PLUS_ONE,
    OP_MINUS_ONE,
    OP_ZERO_MINUS_CHECK,
    OP_REGISTER_ZEROING,
    OP_REGISTER_ALL_ONES,
    OP_UNSIGNED_PRODUCT,
    OP_SIGNED_PRODUCT,
    OP_MIXED_SIGN_PRODUCT,
    OP_FRACTIONAL_UNSIGNED_PRODUCT,
    OP_FRACTIONAL_SIGNED_PRODUCT,
    OP_FRACTIONAL_MIXED_PRODUCT
  } op_t;

  // Request from the decoder and register file
  typedef struct packed {
    op_t                     op;
    logic [`DATA_W-1:0]      dest_value;
    logic [`DATA_W-1:0]      source_register;
    logic [`WORD_W-1:0]      word_value;
    logic [4:0]              dest_index;
  } alu_req_t;

  // Flag vector: H S V N Z C
  typedef logic [5:0] flags_t;

  // Result toward the register file
  typedef struct packed {
    logic                    write_byte;
    logic                    write_word;
    logic                    write_product;
    logic [4:0]              dest_index;
    logic [`WORD_W-1:0]      value;
  } alu_res_t;

endpackage : alu_pkg

`default_nettype wire

// ### rtl/alu_multiplier.sv
// 8x8 multiplier with per-operand signedness and optional fractional shift.
// Assumes operands held stable by the caller for the cycle it is sampled.
`default_nettype none
`include "alu_regs.svh"

module alu_multiplier
  import alu_pkg::*;
#(
  parameter int W = `DATA_W
) (
  input  wire logic [W-1:0]   a_i,
  input  wire logic [W-1:0]   b_i,
  input  wire logic           a_signed_i,
  input  wire logic           b_signed_i,
  input  wire logic           fractional_i,
  output logic [2*W-1:0]      product_o,
  output logic                carry_o
);

  logic signed [2*W+1:0] a_ext;
  logic signed [2*W+1:0] b_ext;
  logic signed [2*W+1:0] full;

  // ************************************************************
  // Product
  // ************************************************************
  always_comb begin
    a_ext = {{(W+2){a_signed_i & a_i[W-1]}}, a_i};
    b_ext = {{(W+2){b_signed_i & b_i[W-1]}}, b_i};
    full  = a_ext * b_ext;
    // Carry is bit 15 of the raw product, taken before the shift
    carry_o = full[2*W-1];
    if (fractional_i) begin
      product_o = {full[2*W-2:0], 1'b0};
    end else begin
      product_o = full[2*W-1:0];
    end
  end

endmodule : alu_multiplier

`default_nettype wire

// ### rtl/alu_core.sv
// Arithmetic and logic datapath of an 8-bit core with status flags.
// Assumes the decoder holds a request one cycle (two for long operations)
// and writes the result back to the register file it owns.
//
// Notes on behaviour
// (RL1) Sum and sum-with-carry write d+s(+C) in 1 cycle; Z C N V H.
// (RL2) Word immediate sum adds constant to pair in 2 cycles; Z C N V S.
// (RL3) Difference and borrow difference write d-s(-C) in 1 cycle; Z C N V H.
// (RL4) Difference constant writes d-K in one cycle; Z C N V H.
// (RL5) Borrow constant difference writes d-K-C; Z C N V H.
// (RL6) Word immediate difference subtracts constant from pair in 2 cycles; Z C N V S.
// (RL7) AND with register or constant in 1 cycle; only Z N V S.
// (RL8) OR with register or constant in 1 cycle; only Z N V S.
// (RL9) Bit setting ORs a mask into destination in one cycle; Z N V.
// (RL10) Bit clearing ANDs with FF minus mask in one cycle; Z N V.
// (RL11) Zero/minus check ANDs register with itself; Z N V.
// (RL12) Integer products into low pair in 2 cycles; only Z and C.
// (RL13) Fractional products shifted left one into low pair, 2 cycles; Z C.
// (RL14) XOR in one cycle Z N V; zeroing is XOR self; all-ones keeps flags.
// (RL15) Invert is FF-d, inverse is 00-d; Z C N V, inverse adds H.
// (RL16) Plus and minus one in one cycle; Z N V, carry unchanged.
`default_nettype none
`include "alu_regs.svh"

module alu_core
  import alu_pkg::*;
#(
  parameter int W = `DATA_W
) (
  input  wire logic     CLK_I,
  input  wire logic     RESET_N_I,
  input  wire logic     REQ_VALID_I,
  input  wire alu_req_t REQ_I,
  output logic          BUSY_O,
  output alu_res_t      RES_O,
  output flags_t        FLAGS_O
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SECOND
  } state_t;

  state_t             state_ff;
  state_t             nxt_state;
  alu_req_t           held_ff;
  alu_res_t           res_ff;
  alu_res_t           nxt_res;
  flags_t             flags_ff;
  flags_t             nxt_flags;
  logic               busy_ff;
  logic [W-1:0]       d;
  logic [W-1:0]       s;
  logic [W-1:0]       r;
  logic [`WORD_W-1:0] wr;
  logic [2*W-1:0]     prod;
  logic               prod_c;
  logic               mul_as;
  logic               mul_bs;
  logic               mul_fr;
  logic               cin;

  function automatic logic is_long(input op_t op);
    is_long = op inside {OP_WORD_IMMEDIATE_SUM, OP_WORD_IMMEDIATE_DIFFERENCE,
                         OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
                         OP_FRACTIONAL_UNSIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT,
                         OP_FRACTIONAL_MIXED_PRODUCT};
  endfunction : is_long

  // Logic result flags: Z N V with V cleared, S from N
  function automatic flags_t logic_flags(input flags_t f, input logic [W-1:0] v);
    logic_flags = f;
    logic_flags[`FLAG_Z] = (v == `ALL_ZEROS);
    logic_flags[`FLAG_N] = v[`SIGN_BIT];
    logic_flags[`FLAG_V] = 1'b0;
    logic_flags[`FLAG_S] = v[`SIGN_BIT];
  endfunction : logic_flags

  // Byte sum/difference flags: Z C N V S H
  function automatic flags_t arith_flags(input flags_t f, input logic [W-1:0] a,
                                         input logic [W-1:0] b, input logic [W-1:0] v,
                                         input logic sub, input logic keep_z);
    logic c7;
    logic h3;
    logic ov;
    logic a7;
    logic b7;
    logic v7;
    logic a3;
    logic b3;
    logic v3;
    a7 = a[`SIGN_BIT];
    b7 = b[`SIGN_BIT];
    v7 = v[`SIGN_BIT];
    a3 = a[`HALF_BIT];
    b3 = b[`HALF_BIT];
    v3 = v[`HALF_BIT];
    if (sub) begin
      c7 = (~a7 & b7) | (b7 & v7) | (v7 & ~a7);
      h3 = (~a3 & b3) | (b3 & v3) | (v3 & ~a3);
      ov = (a7 & ~b7 & ~v7) | (~a7 & b7 & v7);
    end else begin
      c7 = (a7 & b7) | (b7 & ~v7) | (~v7 & a7);
      h3 = (a3 & b3) | (b3 & ~v3) | (~v3 & a3);
      ov = (a7 & b7 & ~v7) | (~a7 & ~b7 & v7);
    end
    arith_flags = f;
    // Borrow variants only keep Z when the result is zero
    arith_flags[`FLAG_Z] = (v == `ALL_ZEROS) & (~keep_z | f[`FLAG_Z]);
    arith_flags[`FLAG_C] = c7;
    arith_flags[`FLAG_H] = h3;
    arith_flags[`FLAG_N] = v[`SIGN_BIT];
    arith_flags[`FLAG_V] = ov;
    arith_flags[`FLAG_S] = v[`SIGN_BIT] ^ ov;
  endfunction : arith_flags

  // ************************************************************
  // Multiplier
  // ************************************************************
  always_comb begin
    mul_as = held_ff.op inside {OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
                                OP_FRACTIONAL_SIGNED_PRODUCT, OP_FRACTIONAL_MIXED_PRODUCT};
    mul_bs = held_ff.op inside {OP_SIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT};
    mul_fr = held_ff.op inside {OP_FRACTIONAL_UNSIGNED_PRODUCT,
                                OP_FRACTIONAL_SIGNED_PRODUCT, OP_FRACTIONAL_MIXED_PRODUCT};
  end

  alu_multiplier #(
    .W (W)
  ) u_mul (
    .a_i          (held_ff.dest_value),
    .b_i          (held_ff.source_register),
    .a_signed_i   (mul_as),
    .b_signed_i   (mul_bs),
    .fractional_i (mul_fr),
    .product_o    (prod),
    .carry_o      (prod_c)
  );

  // ************************************************************
  // Next result and flags
  // ************************************************************
  always_comb begin
    d         = REQ_I.dest_value;
    s         = REQ_I.source_register;
    cin       = flags_ff[`FLAG_C];
    r         = `ALL_ZEROS;
    wr        = `ZERO_WORD;
    nxt_flags = flags_ff;
    nxt_state = state_ff;
    nxt_res   = '0;
    nxt_res.dest_index = REQ_I.dest_index;
    unique case (state_ff)
      ST_IDLE: begin
        if (REQ_VALID_I && is_long(REQ_I.op)) begin
          nxt_state = ST_SECOND;
        end else if (REQ_VALID_I) begin
          nxt_res.write_byte = 1'b1;
          unique case (REQ_I.op)
            OP_SUM: begin
              r = W'(d + s); // RL1
              nxt_flags = arith_flags(flags_ff, d, s, r, 1'b0, 1'b0); // RL1
            end
            OP_SUM_CARRY: begin
              r = W'(d + s + {{(W-1){1'b0}}, cin}); // RL1
              nxt_flags = arith_flags(flags_ff, d, s, r, 1'b0, 1'b0); // RL1
            end
            OP_DIFFERENCE, OP_DIFFERENCE_CONSTANT: begin
              r = W'(d - s); // RL3 RL4
              nxt_flags = arith_flags(flags_ff, d, s, r, 1'b1, 1'b0); // RL3 RL4
            end
            OP_BORROW_DIFFERENCE, OP_BORROW_CONSTANT_DIFFERENCE: begin
              r = W'(d - s - {{(W-1){1'b0}}, cin}); // RL3 RL5
              nxt_flags = arith_flags(flags_ff, d, s, r, 1'b1, 1'b1); // RL3 RL5
            end
            OP_AND: begin
              r = d & s; // RL7
              nxt_flags = logic_flags(flags_ff, r); // RL7
            end
            OP_OR, OP_BIT_SETTING: begin
              r = d | s; // RL8 RL9
              nxt_flags = logic_flags(flags_ff, r); // RL8 RL9
            end
            OP_BIT_CLEARING: begin
              r = d & W'(`ALL_ONES - s); // RL10
              nxt_flags = logic_flags(flags_ff, r); // RL10
            end
            OP_ZERO_MINUS_CHECK: begin
              r = d & d; // RL11
              nxt_flags = logic_flags(flags_ff, r); // RL11
            end
            OP_EXCLUSIVE_OR: begin
              r = d ^ s; // RL14
              nxt_flags = logic_flags(flags_ff, r); // RL14
            end
            OP_REGISTER_ZEROING: begin
              r = d ^ d; // RL14
              nxt_flags = logic_flags(flags_ff, r); // RL14
            end
            OP_REGISTER_ALL_ONES: begin
              r = `ALL_ONES; // RL14
            end
            OP_BITWISE_INVERT: begin
              r = W'(`ALL_ONES - d); // RL15
              nxt_flags = logic_flags(flags_ff, r);
              nxt_flags[`FLAG_C] = 1'b1; // RL15
            end
            OP_ARITHMETIC_INVERSE: begin
              r = W'(`ALL_ZEROS - d); // RL15
              nxt_flags = arith_flags(flags_ff, `ALL_ZEROS, d, r, 1'b1, 1'b0); // RL15
            end
            OP_PLUS_ONE, OP_MINUS_ONE: begin
              r = (REQ_I.op == OP_PLUS_ONE) ? W'(d + `ONE_BYTE) : W'(d - `ONE_BYTE); // RL16
              nxt_flags = logic_flags(flags_ff, r);
              nxt_flags[`FLAG_V] = (REQ_I.op == OP_PLUS_ONE) ? (d == `MAX_POS) : (d == `MIN_NEG);
              nxt_flags[`FLAG_S] = r[`SIGN_BIT] ^ nxt_flags[`FLAG_V]; // RL16
            end
            default: begin
              nxt_res.write_byte = 1'b0;
            end
          endcase
          nxt_res.value = {{(`WORD_W-W){1'b0}}, r};
        end
      end
      ST_SECOND: begin
        nxt_state = ST_IDLE;
        nxt_res.dest_index = held_ff.dest_index;
        if (held_ff.op == OP_WORD_IMMEDIATE_SUM) begin
          wr = held_ff.word_value + {{(`WORD_W-W){1'b0}}, held_ff.source_register}; // RL2
          nxt_flags[`FLAG_V] = ~held_ff.word_value[`WORD_SIGN_BIT] & wr[`WORD_SIGN_BIT];
          nxt_flags[`FLAG_C] = ~wr[`WORD_SIGN_BIT] & held_ff.word_value[`WORD_SIGN_BIT];
          nxt_res.write_word = 1'b1;
        end else if (held_ff.op == OP_WORD_IMMEDIATE_DIFFERENCE) begin
          wr = held_ff.word_value - {{(`WORD_W-W){1'b0}}, held_ff.source_register}; // RL6
          nxt_flags[`FLAG_V] = held_ff.word_value[`WORD_SIGN_BIT] & ~wr[`WORD_SIGN_BIT];
          nxt_flags[`FLAG_C] = wr[`WORD_SIGN_BIT] & ~held_ff.word_value[`WORD_SIGN_BIT];
          nxt_res.write_word = 1'b1;
        end else begin
          wr = prod; // RL12 RL13
          nxt_flags[`FLAG_C] = prod_c; // RL12 RL13
          nxt_res.write_product = 1'b1;
        end
        nxt_flags[`FLAG_Z] = (wr == `ZERO_WORD);
        if (nxt_res.write_word) begin
          nxt_flags[`FLAG_N] = wr[`WORD_SIGN_BIT]; // RL2 RL6
          nxt_flags[`FLAG_S] = wr[`WORD_SIGN_BIT] ^ nxt_flags[`FLAG_V]; // RL2 RL6
        end
        nxt_res.value = wr;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ************************************************************
  // State and held request
  // ************************************************************
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_ff <= ST_IDLE;
      busy_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff  <= (nxt_state == ST_SECOND);
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      held_ff <= '0;
    end else if (state_ff == ST_IDLE && REQ_VALID_I) begin
      held_ff <= REQ_I;
    end
  end

  // ************************************************************
  // Result and flags
  // ************************************************************
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      res_ff   <= '0;
      flags_ff <= `FLAGS_RESET;
    end else begin
      res_ff   <= nxt_res;
      flags_ff <= nxt_flags;
    end
  end

  assign BUSY_O  = busy_ff;
  assign RES_O   = res_ff;
  assign FLAGS_O = flags_ff;

endmodule : alu_core

`default_nettype wire

// ### testbench/alu_core_assertions.sv
// Port checker for the arithmetic and logic datapath.
// Assumes alu_pkg is compiled first; bound to alu_core after the module.
`default_nettype none
`include "alu_regs.svh"

module alu_core_assertions
  import alu_pkg::*;
(
  input wire logic     CLK_I,
  input wire logic     RESET_N_I,
  input wire logic     REQ_VALID_I,
  input wire alu_req_t REQ_I,
  input wire logic     BUSY_O,
  input wire alu_res_t RES_O,
  input wire flags_t   FLAGS_O
);
  // ****
  // Request decode
  // ****
  logic tk;
  logic prod;
  logic word;
  assign tk   = REQ_VALID_I && !BUSY_O;
  assign prod = REQ_I.op >= OP_UNSIGNED_PRODUCT;
  assign word = REQ_I.op inside {OP_WORD_IMMEDIATE_SUM, OP_WORD_IMMEDIATE_DIFFERENCE};

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence word_done; BUSY_O ##1 (RES_O.write_word && !BUSY_O); endsequence
  sequence prod_done; BUSY_O ##1 (RES_O.write_product && !BUSY_O); endsequence

  // ****
  // Checks
  // ****
  chk_short_write: assert property (tk && !word && !prod && REQ_I.op != OP_NONE
    |=> RES_O.write_byte && RES_O.dest_index == $past(REQ_I.dest_index)) else $error("short write");
  chk_word_timing: assert property (tk && word |=> word_done) else $error("word timing");
  chk_prod_timing: assert property (tk && prod |=> prod_done) else $error("product timing");
  chk_sum_value: assert property (tk && REQ_I.op == OP_SUM
    |=> RES_O.value[7:0] == $past(REQ_I.dest_value + REQ_I.source_register)) else $error("sum");
  chk_diff_value: assert property (tk && REQ_I.op == OP_DIFFERENCE_CONSTANT
    |=> RES_O.value[7:0] == $past(REQ_I.dest_value - REQ_I.source_register)) else $error("diff");
  chk_clear_value: assert property (tk && REQ_I.op == OP_BIT_CLEARING
    |=> RES_O.value[7:0] == $past(REQ_I.dest_value & (8'hFF - REQ_I.source_register)))
    else $error("bit clear");
  chk_ones_flags: assert property (tk && REQ_I.op == OP_REGISTER_ALL_ONES && !$past(BUSY_O)
    |=> RES_O.value[7:0] == 8'hFF && $stable(FLAGS_O)) else $error("all ones");
  chk_step_carry: assert property (tk && !$past(BUSY_O) && REQ_I.op inside {OP_PLUS_ONE, OP_MINUS_ONE}
    |=> FLAGS_O[`FLAG_C] == $past(FLAGS_O[`FLAG_C])) else $error("step carry");
  chk_logic_keep: assert property (tk && !$past(BUSY_O) && REQ_I.op inside {OP_AND, OP_OR}
    |=> $stable(FLAGS_O[`FLAG_C]) && $stable(FLAGS_O[`FLAG_H])) else $error("logic flags");
  chk_prod_zero: assert property (tk && prod
    |-> ##2 FLAGS_O[`FLAG_Z] == (RES_O.value == 16'h0000)) else $error("product zero");
endmodule : alu_core_assertions

bind alu_core alu_core_assertions u_chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
  .REQ_VALID_I(REQ_VALID_I), .REQ_I(REQ_I), .BUSY_O(BUSY_O), .RES_O(RES_O), .FLAGS_O(FLAGS_O));

`default_nettype wire

// ### testbench/alu_core_tb.sv
// Self-checking bench for the arithmetic and logic datapath.
// Assumes alu_pkg, alu_core and the checker are compiled before it.
`default_nettype none
`include "alu_regs.svh"

module alu_core_tb
  import alu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic     CLK_I = 1'b0;
  logic     RESET_N_I = 1'b0;
  logic     REQ_VALID_I = 1'b0;
  alu_req_t REQ_I = '0;
  logic     BUSY_O;
  alu_res_t RES_O;
  flags_t   FLAGS_O;
  int       errors = 0;
  int       samples_checked = 0;
  int       cycles = 0;

  always #20 CLK_I = ~CLK_I;

  alu_core u_dut (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .REQ_VALID_I(REQ_VALID_I),
    .REQ_I(REQ_I), .BUSY_O(BUSY_O), .RES_O(RES_O), .FLAGS_O(FLAGS_O));

  // ****
  // Shared tasks
  // ****
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic check_val(input string what, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : check_val

  task automatic check_flags(input flags_t m, input flags_t e);
    samples_checked++;
    if ((FLAGS_O & m) !== (e & m)) begin
      errors++;
      $display("wrong value flags expected %h seen %h", e & m, FLAGS_O & m);
    end
  endtask : check_flags

  // Lets one falling edge pass so valid never falls and rises in one step;
  // returns at the falling edge after the take
  task automatic issue(input op_t op, input logic [7:0] d, input logic [7:0] s,
                       input logic [15:0] w);
    @(negedge CLK_I);
    REQ_I = '{op: op, dest_value: d, source_register: s, word_value: w, dest_index: 5'h11};
    REQ_VALID_I = 1'b1;
    @(negedge CLK_I);
    REQ_VALID_I = 1'b0;
  endtask : issue

  task automatic short_op(input op_t op, input logic [7:0] d, input logic [7:0] s,
                          input logic [7:0] e, input flags_t m, input flags_t f);
    issue(op, d, s, 16'h0000);
    check_val("byte strobe", 16'h0001, {15'h0, RES_O.write_byte});
    check_val("byte value", {8'h00, e}, {8'h00, RES_O.value[7:0]});
    check_val("byte index", 16'h0011, {11'h000, RES_O.dest_index});
    check_flags(m, f);
  endtask : short_op

  task automatic long_op(input op_t op, input logic [7:0] d, input logic [15:0] w,
                         input logic [15:0] e, input flags_t m, input flags_t f);
    issue(op, d, 8'h02, w);
    check_val("busy", 16'h0001, {15'h0, BUSY_O});
    @(negedge CLK_I);
    check_val("long strobe", 16'h0001, {15'h0, RES_O.write_word | RES_O.write_product});
    check_val("long value", e, RES_O.value);
    check_val("long index", 16'h0011, {11'h000, RES_O.dest_index});
    check_flags(m, f);
  endtask : long_op

  // ****
  // Scenarios
  // ****
  task automatic test_sum;
    short_op(OP_SUM, 8'h7F, 8'h01, 8'h80, 6'h2F, 6'h2C);
    short_op(OP_SUM, 8'hFF, 8'h01, 8'h00, 6'h2F, 6'h23);
    short_op(OP_SUM_CARRY, 8'h10, 8'h20, 8'h31, 6'h2F, 6'h00);
    $display("sum test done");
  endtask : test_sum

  task automatic test_diff;
    short_op(OP_DIFFERENCE, 8'h00, 8'h01, 8'hFF, 6'h2F, 6'h25);
    short_op(OP_BORROW_DIFFERENCE, 8'h10, 8'h0F, 8'h00, 6'h2F, 6'h20);
    short_op(OP_SUM, 8'hFF, 8'h01, 8'h00, 6'h2F, 6'h23);
    short_op(OP_BORROW_CONSTANT_DIFFERENCE, 8'h05, 8'h04, 8'h00, 6'h2F, 6'h02);
    short_op(OP_DIFFERENCE_CONSTANT, 8'h80, 8'h01, 8'h7F, 6'h2F, 6'h28);
    $display("difference test done");
  endtask : test_diff

  task automatic test_logic;
    short_op(OP_AND, 8'hF0, 8'h3C, 8'h30, 6'h0E, 6'h00);
    short_op(OP_OR, 8'h00, 8'h00, 8'h00, 6'h0E, 6'h02);
    short_op(OP_EXCLUSIVE_OR, 8'h80, 8'h00, 8'h80, 6'h0E, 6'h04);
    short_op(OP_BIT_SETTING, 8'h01, 8'h80, 8'h81, 6'h0E, 6'h04);
    short_op(OP_BIT_CLEARING, 8'hFF, 8'h0F, 8'hF0, 6'h0E, 6'h04);
    short_op(OP_ZERO_MINUS_CHECK, 8'h00, 8'h00, 8'h00, 6'h0E, 6'h02);
    short_op(OP_REGISTER_ZEROING, 8'h55, 8'h55, 8'h00, 6'h0E, 6'h02);
    short_op(OP_REGISTER_ALL_ONES, 8'h00, 8'h00, 8'hFF, 6'h3F, 6'h22);
    $display("logic test done");
  endtask : test_logic

  task automatic test_unary;
    short_op(OP_BITWISE_INVERT, 8'h0F, 8'h00, 8'hF0, 6'h0F, 6'h05);
    short_op(OP_ARITHMETIC_INVERSE, 8'h01, 8'h00, 8'hFF, 6'h2F, 6'h25);
    short_op(OP_PLUS_ONE, 8'h7F, 8'h00, 8'h80, 6'h0F, 6'h0D);
    short_op(OP_MINUS_ONE, 8'h80, 8'h00, 8'h7F, 6'h0F, 6'h09);
    $display("unary test done");
  endtask : test_unary

  task automatic test_word;
    long_op(OP_WORD_IMMEDIATE_SUM, 8'h00, 16'h00FF, 16'h0101, 6'h1F, 6'h00);
    long_op(OP_WORD_IMMEDIATE_DIFFERENCE, 8'h00, 16'h0001, 16'hFFFF, 6'h1F, 6'h15);
    // Valid stays up across the busy cycle with a byte sum that must be refused
    @(negedge CLK_I);
    REQ_I = '{op: OP_WORD_IMMEDIATE_SUM, dest_value: 8'h00, source_register: 8'h01,
              word_value: 16'h7FFF, dest_index: 5'h11};
    REQ_VALID_I = 1'b1;
    @(negedge CLK_I);
    REQ_I.op = OP_SUM;
    @(negedge CLK_I);
    REQ_VALID_I = 1'b0;
    check_val("refused word value", 16'h8000, RES_O.value);
    check_flags(6'h1F, 6'h0C);
    @(negedge CLK_I);
    check_val("refused strobe", 16'h0000, {15'h0, RES_O.write_byte});
    $display("word test done");
  endtask : test_word

  task automatic test_product;
    op_t         ops[6] = '{OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
                            OP_FRACTIONAL_UNSIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT,
                            OP_FRACTIONAL_MIXED_PRODUCT};
    logic [15:0] exps[6] = '{16'h01FE, 16'hFFFE, 16'hFFFE, 16'h03FC, 16'hFFFC, 16'hFFFC};
    flags_t      cs[6] = '{6'h00, 6'h01, 6'h01, 6'h00, 6'h01, 6'h01};
    for (int i = 0; i < 6; i++) begin
      long_op(ops[i], 8'hFF, 16'h0000, exps[i], 6'h03, cs[i]);
    end
    issue(OP_UNSIGNED_PRODUCT, 8'h00, 8'h55, 16'h0000);
    @(negedge CLK_I);
    check_val("zero product", 16'h0000, RES_O.value);
    check_flags(6'h03, 6'h02);
    $display("product test done");
  endtask : test_product

  always @(posedge CLK_I) begin
    cycles++;
    if (cycles == 1000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    repeat (5) @(negedge CLK_I);
    RESET_N_I = 1'b1;
    test_sum();
    test_diff();
    test_logic();
    test_unary();
    test_word();
    test_product();
    final_report();
  end
endmodule : alu_core_tb

`default_nettype wire
